/* verilog/fshc_core.sv */
/*
 Status and control registers of a serial flash die with the bus pause
 and reset-pin functions. Decodes the serial commands that touch them.
 Assumes the host drives serial clock and select well below 20 MHz so the
 40 MHz system clock sees every edge; rst_b is the power cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fshc_core (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic si_pin,
   input wire logic pause_pin_n,
   input wire logic write_guard_pin_n,
   output logic so_out,
   output logic so_oe_n,
   output logic program_busy_flag,
   output logic [1:0] output_strength_sel,
   output logic [4:0] guard_bits_eff,
   output logic guard_invert_eff,
   output logic protect_scheme_select,
   output logic sector_guard_preset,
   output logic [2:0] secure_area_lock_bits,
   output logic current_addr_width_flag
);
   import fshc_pkg::*;

   logic sclk_s, cs_n_s, si_s, hold_s, wp_s, sclk_q, cs_q;
   logic paused, pause_en, rise, fall, cs_rise, exec, soft_rst, pin_rst;
   logic [5:0] bitcnt;
   logic [7:0] sh, opcode, arg, osh, rd_byte;
   logic write_latch_flag, vol_wen, active_die, rst_arm, init_pend;
   logic [4:0] array_guard_bits;
   logic [1:0] status_lock_mode;
   logic quad_io_enable, guard_invert, erase_paused_flag, program_paused_flag;
   logic powerup_addr_width, pause_or_reset_pin_select;
   fshc_op_t busy_kind;
   logic [11:0] busy_cnt;
   logic [7:0] status_byte_one, status_byte_two, status_byte_three;
   logic n8, n16, idle, susp, lock_ok, wr_ok, erase_ok, rd_op, acc, addr_done;
   logic do_wrsr, do_prog, do_erase, do_chip, do_susp, do_resume, op_end;

   // ************************************
   // Pin sampling
   // ************************************
   fshc_sync #(.INIT(1'b0)) u_sclk (.clk(clk), .rst_b(rst_b), .pin(sclk_pin), .level(sclk_s));
   fshc_sync #(.INIT(1'b1)) u_cs (.clk(clk), .rst_b(rst_b), .pin(cs_n_pin), .level(cs_n_s));
   fshc_sync #(.INIT(1'b0)) u_si (.clk(clk), .rst_b(rst_b), .pin(si_pin), .level(si_s));
   fshc_sync #(.INIT(1'b1)) u_hold (.clk(clk), .rst_b(rst_b), .pin(pause_pin_n), .level(hold_s));
   fshc_sync #(.INIT(1'b1)) u_wp (.clk(clk), .rst_b(rst_b), .pin(write_guard_pin_n), .level(wp_s));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         sclk_q <= sclk_s;
         cs_q <= cs_n_s;
      end
   end

   // ************************************
   // Decode
   // ************************************
   assign pause_en = !quad_io_enable && !pause_or_reset_pin_select;
   assign pin_rst = !quad_io_enable && pause_or_reset_pin_select && !hold_s;
   // Edge history keeps running in a pause, so resuming makes no false edge
   assign rise = sclk_s && !sclk_q && !cs_n_s && !paused;
   assign fall = !sclk_s && sclk_q && !cs_n_s && !paused;
   assign cs_rise = cs_n_s && !cs_q;
   assign exec = cs_rise && !paused && !pin_rst;
   assign n8 = (bitcnt == CNT_OPCODE);
   assign n16 = (bitcnt == CNT_ARG);
   assign addr_done = (bitcnt >= (current_addr_width_flag ? CNT_ADDR4 : CNT_ADDR3));
   assign idle = (busy_kind == FSHC_IDLE);
   assign susp = erase_paused_flag || program_paused_flag;
   assign acc = active_die;
   assign rd_op = acc && (bitcnt >= CNT_OPCODE) &&
                  (opcode == OP_RD1 || opcode == OP_RD2 || opcode == OP_RD3);

   always_comb begin
      case (status_lock_mode)
         2'b00: lock_ok = 1'b1;
         2'b01: lock_ok = quad_io_enable || wp_s;
         default: lock_ok = 1'b0;
      endcase
   end

   assign wr_ok = (write_latch_flag || vol_wen) && idle && lock_ok;
   assign do_wrsr = exec && acc && n16 && wr_ok &&
                    (opcode == OP_WR1 || opcode == OP_WR2 || opcode == OP_WR3);
   assign do_prog = exec && acc && write_latch_flag && idle && !susp && addr_done && opcode == OP_PROG;
   assign do_erase = exec && acc && write_latch_flag && idle && !susp && addr_done &&
                     (opcode == OP_SEC_ERASE || opcode == OP_BLK_ERASE);
   // Sector scheme leaves the guard bits without effect
   assign erase_ok = protect_scheme_select ||
                     (array_guard_bits[2:0] == 3'h0 && !guard_invert) ||
                     (array_guard_bits[2:0] == 3'h7 && guard_invert);
   assign do_chip = exec && acc && n8 && write_latch_flag && idle && !susp && erase_ok && opcode == OP_CHIP_ERASE;
   assign do_susp = exec && acc && n8 && opcode == OP_SUSPEND && !susp &&
                    (busy_kind == FSHC_PROG || busy_kind == FSHC_ERASE);
   assign do_resume = exec && acc && n8 && opcode == OP_RESUME;
   assign soft_rst = pin_rst || (exec && n8 && rst_arm && opcode == OP_RST_GO);
   assign op_end = !idle && !susp && busy_cnt == 12'h001;

   // ************************************
   // Serial shift and pause
   // ************************************
   always_ff @(posedge clk) begin
      if (!rst_b || cs_n_s || pin_rst) begin
         bitcnt <= 6'h00;
         sh <= 8'h00;
         opcode <= 8'h00;
         arg <= 8'h00;
      end else if (rise) begin
         sh <= {sh[6:0], si_s};
         if (bitcnt != 6'h3f) begin
            bitcnt <= bitcnt + 6'h01;
         end
         if (bitcnt == CNT_OPCODE - 6'h01) begin
            opcode <= {sh[6:0], si_s};
         end
         if (bitcnt == CNT_ARG - 6'h01) begin
            arg <= {sh[6:0], si_s};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         paused <= 1'b0;
      end else if (cs_n_s || !pause_en) begin
         paused <= 1'b0;
      end else if (!paused && !hold_s && !sclk_s) begin
         paused <= 1'b1;
      end else if (paused && hold_s && !sclk_s) begin
         paused <= 1'b0;
      end
   end

   // ************************************
   // Serial output
   // ************************************
   always_comb begin
      case (opcode)
         OP_RD2: rd_byte = status_byte_two;
         OP_RD3: rd_byte = status_byte_three;
         default: rd_byte = status_byte_one;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         so_out <= 1'b0;
         osh <= 8'h00;
         so_oe_n <= 1'b1;
      end else begin
         so_oe_n <= !(rd_op && !cs_n_s && !paused && !pin_rst);
         if (fall && rd_op) begin
            if (bitcnt[2:0] == 3'h0) begin
               so_out <= rd_byte[7];
               osh <= {rd_byte[6:0], 1'b0};
            end else begin
               so_out <= osh[7];
               osh <= {osh[6:0], 1'b0};
            end
         end
      end
   end

   // ************************************
   // Busy and suspend
   // ************************************
   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         busy_kind <= FSHC_IDLE;
         busy_cnt <= 12'h000;
      end else if (do_wrsr) begin
         busy_kind <= FSHC_WRSR;
         busy_cnt <= WRSR_CYC;
      end else if (do_prog) begin
         busy_kind <= FSHC_PROG;
         busy_cnt <= PROG_CYC;
      end else if (do_erase || do_chip) begin
         busy_kind <= FSHC_ERASE;
         busy_cnt <= ERASE_CYC;
      end else if (!idle && !susp) begin
         busy_cnt <= busy_cnt - 12'h001;
         if (op_end) begin
            busy_kind <= FSHC_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         erase_paused_flag <= 1'b0;
         program_paused_flag <= 1'b0;
      end else if (do_resume) begin
         erase_paused_flag <= 1'b0;
         program_paused_flag <= 1'b0;
      end else if (do_susp) begin
         erase_paused_flag <= (busy_kind == FSHC_ERASE);
         program_paused_flag <= (busy_kind == FSHC_PROG);
      end
   end

   // ************************************
   // Write latches, die select, reset arm
   // ************************************
   // Set applied last so a set meeting a clear wins
   always_ff @(posedge clk) begin
      if (!rst_b || soft_rst) begin
         write_latch_flag <= 1'b0;
         vol_wen <= 1'b0;
      end else begin
         if (op_end || (exec && acc && n8 && opcode == OP_WRDI)) begin
            write_latch_flag <= 1'b0;
         end
         if (do_wrsr || (exec && acc && n8 && opcode == OP_WRDI)) begin
            vol_wen <= 1'b0;
         end
         if (exec && acc && n8 && opcode == OP_WREN) begin
            write_latch_flag <= 1'b1;
         end
         if (exec && acc && n8 && opcode == OP_VWREN) begin
            vol_wen <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         active_die <= 1'b1;
         rst_arm <= 1'b0;
      end else begin
         if (exec && n16 && opcode == OP_DIE_SEL) begin
            active_die <= (arg == OWN_DIE_ID);
         end
         if (exec) begin
            rst_arm <= n8 && opcode == OP_RST_ARM;
         end
      end
   end

   // ************************************
   // Status fields
   // ************************************
   // Power cycle returns every field, lock mode included, to factory value
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         array_guard_bits <= GUARD_RST;
         status_lock_mode <= LOCK_RST;
         quad_io_enable <= 1'b0;
         secure_area_lock_bits <= SEC_RST;
         guard_invert <= 1'b0;
         powerup_addr_width <= 1'b0;
         protect_scheme_select <= 1'b0;
         output_strength_sel <= DRV_RST;
         pause_or_reset_pin_select <= 1'b0;
      end else if (do_wrsr) begin
         case (opcode)
            OP_WR1: begin
               array_guard_bits <= arg[6:2];
               status_lock_mode[0] <= arg[7];
            end
            OP_WR2: begin
               status_lock_mode[1] <= arg[0];
               quad_io_enable <= arg[1];
               secure_area_lock_bits <= secure_area_lock_bits | arg[5:3];
               guard_invert <= arg[6];
            end
            default: begin
               // Power-up width needs the non-volatile latch, not the volatile one
               if (write_latch_flag) begin
                  powerup_addr_width <= arg[1];
               end
               protect_scheme_select <= protect_scheme_select | arg[2];
               output_strength_sel <= arg[6:5];
               pause_or_reset_pin_select <= arg[7];
            end
         endcase
      end
   end

   // ************************************
   // Address width
   // ************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         init_pend <= 1'b1;
         current_addr_width_flag <= 1'b0;
      end else begin
         init_pend <= 1'b0;
         if (init_pend || soft_rst) begin
            current_addr_width_flag <= powerup_addr_width;
         end else if (exec && acc && n8 && opcode == OP_ENTER4) begin
            current_addr_width_flag <= 1'b1;
         end else if (exec && acc && n8 && opcode == OP_EXIT4) begin
            current_addr_width_flag <= 1'b0;
         end
      end
   end

   // ************************************
   // Status bytes and outputs
   // ************************************
   assign program_busy_flag = !idle && !susp;
   assign status_byte_one = {status_lock_mode[0], array_guard_bits, write_latch_flag, program_busy_flag};
   assign status_byte_two = {erase_paused_flag, guard_invert, secure_area_lock_bits,
                             program_paused_flag, quad_io_enable, status_lock_mode[1]};
   assign status_byte_three = {pause_or_reset_pin_select, output_strength_sel, RSVD_VAL,
                               protect_scheme_select, powerup_addr_width, current_addr_width_flag};
   assign guard_bits_eff = protect_scheme_select ? GUARD_RST : array_guard_bits;
   assign guard_invert_eff = guard_invert && !protect_scheme_select;
   // Soft and pin resets preset the guards too, since power-up clears the scheme bit
   assign sector_guard_preset = (init_pend || soft_rst) && protect_scheme_select;

   // ************************************
   // Checks
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_pause_req;
      !paused && pause_en && !cs_n_s && !hold_s && !sclk_s;
   endsequence
   sequence s_pause_exit;
      paused && pause_en && !cs_n_s && hold_s && !sclk_s;
   endsequence

   a_pause_floats: assert property (paused |=> so_oe_n) else $error("output driven in pause");
   a_pause_entry: assert property (s_pause_req |=> paused [*1] ##1 (paused || hold_s || cs_n_s))
      else $error("pause not entered");
   a_pause_leave: assert property (s_pause_exit |=> !paused) else $error("pause not left");
   a_deselect_abort: assert property (paused && cs_n_s |=> !paused && bitcnt == 6'h00)
      else $error("deselect did not abort");
   a_busy_report: assert property (do_prog |=> status_byte_one[0] [*8])
      else $error("busy flag not raised");
   a_latch_gate: assert property (exec && !write_latch_flag && !vol_wen |=> $stable(array_guard_bits) && (idle || !$past(idle)))
      else $error("write accepted without latch");
   a_chip_guard: assert property (exec && n8 && opcode == OP_CHIP_ERASE && !erase_ok && idle |=> idle)
      else $error("chip erase not refused");
   a_lock_hold: assert property (status_lock_mode[1] && exec |=> $stable(status_lock_mode) && $stable(quad_io_enable))
      else $error("locked status written");
   a_otp_sticky: assert property ((($past(secure_area_lock_bits) & ~secure_area_lock_bits) == 3'h0) &&
                                  !($past(protect_scheme_select) && !protect_scheme_select))
      else $error("one-time bit cleared");
   a_suspend_flag: assert property (do_susp |=> (erase_paused_flag == (busy_kind == FSHC_ERASE)) &&
                                    (program_paused_flag == (busy_kind == FSHC_PROG)) ##1 !program_busy_flag)
      else $error("suspend flags wrong");
   a_width_init: assert property (init_pend |=> current_addr_width_flag == $past(powerup_addr_width))
      else $error("power-up width not applied");
endmodule
`default_nettype wire

/* verilog/fshc_pkg.sv */
/*
 Constants for the flash status and pause control block: opcodes, serial bit
 counts, reset values and busy timings.
 Assumes a 40 MHz system clock that oversamples the serial bus pins.
*/
// Overview of operation
// - Pause floats output, freezes clock and input
// - Pause starts: pin low, selected, clock low
// - Pause ends: pin high, clock low, transfer resumes
// - Deselect during pause aborts the command
// - Busy flag shows program, erase, status write
// - Write latch clear rejects program and erase commands
// - Guard bits shield regions, writable unless locked
// - Chip erase only with matching guard bits
// - Lock mode 00 obeys latch, 01 obeys latch and guard pin
// - Lock mode 10 refuses writes until power cycle
// - Lock mode 11 refuses writes until power cycle
// - Quad enable turns control pins into data
// - Secure area locks set once, clear only at power cycle
// - Guard invert selects the complementary region
// - Suspend sets paused flags, resume clears them
// - Address width flag shows three or four bytes
// - Power-up width sampled at init, needs latch
// - Start in width chosen by power-up bit
// - Pin select picks pause or reset function
// - Scheme select is one-way, overrides guard bits and invert
// - Sector scheme presets volatile guards, ignores bits
// - Strength select sets read output drive
// - Idle die accepts only select and reset
package fshc_pkg;

   // ************************************
   // Opcodes
   // ************************************
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_VWREN = 8'h50;
   localparam logic [7:0] OP_RD1 = 8'h05;
   localparam logic [7:0] OP_RD2 = 8'h35;
   localparam logic [7:0] OP_RD3 = 8'h15;
   localparam logic [7:0] OP_WR1 = 8'h01;
   localparam logic [7:0] OP_WR2 = 8'h31;
   localparam logic [7:0] OP_WR3 = 8'h11;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_ENTER4 = 8'hb7;
   localparam logic [7:0] OP_EXIT4 = 8'he9;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_SEC_ERASE = 8'h20;
   localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
   localparam logic [7:0] OP_DIE_SEL = 8'hc2;
   localparam logic [7:0] OP_RST_ARM = 8'h66;
   localparam logic [7:0] OP_RST_GO = 8'h99;

   // ************************************
   // Die, field and reset values
   // ************************************
   // Own die number; value arbitrary
   localparam logic [7:0] OWN_DIE_ID = 8'h00;
   localparam logic [1:0] RSVD_VAL = 2'h0;
   localparam logic [4:0] GUARD_RST = 5'h00;
   localparam logic [1:0] LOCK_RST = 2'h0;
   localparam logic [2:0] SEC_RST = 3'h0;
   localparam logic [1:0] DRV_RST = 2'h0;
   localparam logic [5:0] CNT_OPCODE = 6'h08;
   localparam logic [5:0] CNT_ARG = 6'h10;
   localparam logic [5:0] CNT_ADDR3 = 6'h20;
   localparam logic [5:0] CNT_ADDR4 = 6'h28;

   // ************************************
   // Busy timing
   // ************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_WRSR_NS = 5000;
   localparam int T_PROG_NS = 10000;
   localparam int T_ERASE_NS = 50000;
   localparam logic [11:0] WRSR_CYC = 12'((T_WRSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] PROG_CYC = 12'((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] ERASE_CYC = 12'((T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {FSHC_IDLE, FSHC_PROG, FSHC_ERASE, FSHC_WRSR} fshc_op_t;

endpackage

/* verilog/fshc_sync.sv */
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes an asynchronous input and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fshc_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   logic s1, s2, s3;

   // ************************************
   // Stages
   // ************************************
   // Output moves only when stages two and three agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         level <= INIT;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/fshc_host.sv */
/*
 Host side of the serial bus: mode 0 transfers with an optional pause or
 abort in mid-frame. Assumes the clk of the block it drives.
*/
`timescale 1ns/1ps
`default_nettype none
module fshc_host (
   input wire logic clk,
   input wire logic so_out,
   input wire logic so_oe_n,
   output var logic sclk_pin,
   output var logic cs_n_pin,
   output var logic si_pin,
   output var logic pause_pin_n
);
   // ************************************
   // Bus driver
   // ************************************
   logic seen_oe_n;
   logic last_so;
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      si_pin = 1'b0;
      pause_pin_n = 1'b1;
      seen_oe_n = 1'b0;
      last_so = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Released line shows the inverse, never a lucky stale value
   function automatic logic so_wire();
      return so_oe_n ? ~last_so : so_out;
   endfunction
   task automatic xfer(input logic [47:0] d, input int n, input int p, input logic ab, output logic [7:0] rd);
      rd = 8'h00;
      tick(1);
      cs_n_pin = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_pin = d[47 - i];
         tick(4);
         if (i == p) begin
            pause_pin_n = 1'b0;
            tick(4);
            sclk_pin = 1'b1;
            si_pin = ~si_pin;
            tick(4);
            sclk_pin = 1'b0;
            si_pin = d[47 - i];
            seen_oe_n = so_oe_n;
            if (ab) begin
               cs_n_pin = 1'b1;
               tick(8);
               pause_pin_n = 1'b1;
               return;
            end
            pause_pin_n = 1'b1;
            tick(8);
         end
         sclk_pin = 1'b1;
         tick(4);
         if (i >= 8) begin
            last_so = so_wire();
            rd = {rd[6:0], last_so};
         end
         sclk_pin = 1'b0;
      end
      tick(4);
      cs_n_pin = 1'b1;
      si_pin = ~si_pin;
      tick(8);
   endtask
endmodule
`default_nettype wire

/* tb/flash_status_and_hold_control_test.sv */
/*
 Self-checking bench for the status and pause block, driven through the
 serial host model. Assumes the 40 MHz clock and package opcodes.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_hold_control_test;
   import fshc_pkg::*;
   // ************************************
   // Harness
   // ************************************
   logic clk, rst_b, write_guard_pin_n;
   wire logic sclk_w, cs_w, si_w, pause_w, so_out, so_oe_n, busy, scheme, preset, aw;
   wire logic [1:0] drv;
   wire logic [4:0] gb;
   wire logic gi;
   wire logic [2:0] lb;
   int err_total, cmp_count;
   logic [7:0] rd;
   logic preset_seen;
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // Mid-cycle sampling of the one-cycle preset pulse
   always @(negedge clk) preset_seen <= rst_b && (preset_seen || preset);
   fshc_host i_host (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n), .sclk_pin(sclk_w), .cs_n_pin(cs_w),
      .si_pin(si_w), .pause_pin_n(pause_w));
   fshc_core i_dut (.clk(clk), .rst_b(rst_b), .sclk_pin(sclk_w), .cs_n_pin(cs_w), .si_pin(si_w),
      .pause_pin_n(pause_w), .write_guard_pin_n(write_guard_pin_n), .so_out(so_out), .so_oe_n(so_oe_n),
      .program_busy_flag(busy), .output_strength_sel(drv), .guard_bits_eff(gb), .guard_invert_eff(gi),
      .protect_scheme_select(scheme), .sector_guard_preset(preset), .secure_area_lock_bits(lb),
      .current_addr_width_flag(aw));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] b, input int n);
      i_host.xfer({op, b, 32'h0}, n, -1, 1'b0, rd);
   endtask
   task automatic rdsr(input logic [7:0] op, input logic [7:0] exp, input string what);
      cmd(op, 8'h00, 16);
      check(what, rd, exp);
   endtask
   // Bounded: longest busy span is the erase
   task automatic wait_idle();
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
      #1;
      check("idle", {7'h0, busy}, 8'h00);
   endtask
   task automatic wsr(input logic [7:0] op, input logic [7:0] b);
      cmd(OP_WREN, 8'h00, 8);
      cmd(op, b, 16);
      wait_idle();
   endtask
   task automatic pwr_cycle();
      rst_b = 1'b0;
      i_host.tick(5);
      rst_b = 1'b1;
      i_host.tick(4);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
   // ************************************
   // Tests
   // ************************************
   initial begin
      rst_b = 1'b0;
      write_guard_pin_n = 1'b1;
      err_total = 0;
      cmp_count = 0;
      pwr_cycle();
      rdsr(OP_RD1, 8'h00, "sr1");
      rdsr(OP_RD2, 8'h00, "sr2");
      rdsr(OP_RD3, 8'h00, "sr3");
      $display("test reset done");
      cmd(OP_WR1, 8'h1c, 16);
      rdsr(OP_RD1, 8'h00, "no latch");
      cmd(OP_WREN, 8'h00, 8);
      rdsr(OP_RD1, 8'h02, "latch");
      cmd(OP_WR1, 8'h1c, 16);
      check("busy", {7'h0, busy}, 8'h01);
      wait_idle();
      check("guard", {3'h0, gb}, 8'h07);
      rdsr(OP_RD1, 8'h1c, "sr1 done");
      cmd(OP_WREN, 8'h00, 8);
      cmd(OP_CHIP_ERASE, 8'h00, 8);
      check("erase refused", {7'h0, busy}, 8'h00);
      wsr(OP_WR1, 8'h00);
      cmd(OP_WREN, 8'h00, 8);
      cmd(OP_CHIP_ERASE, 8'h00, 8);
      check("erase", {7'h0, busy}, 8'h01);
      wait_idle();
      $display("test guard done");
      for (int j = 0; j < 4; j++) begin
         wsr(OP_WR3, 8'(j << 5));
         check("strength", {6'h0, drv}, 8'(j));
      end
      $display("test strength done");
      wsr(OP_WR1, 8'h80);
      write_guard_pin_n = 1'b0;
      wsr(OP_WR1, 8'h84);
      check("guard pin low", {3'h0, gb}, 8'h00);
      write_guard_pin_n = 1'b1;
      wsr(OP_WR1, 8'h84);
      check("guard pin high", {3'h0, gb}, 8'h01);
      wsr(OP_WR2, 8'h01);
      wsr(OP_WR1, 8'h08);
      check("otp lock", {3'h0, gb}, 8'h01);
      pwr_cycle();
      wsr(OP_WR2, 8'h01);
      wsr(OP_WR1, 8'h08);
      check("lockdown", {3'h0, gb}, 8'h00);
      pwr_cycle();
      rdsr(OP_RD2, 8'h00, "lock cleared");
      $display("test lock done");
      cmd(OP_WREN, 8'h00, 8);
      cmd(OP_PROG, 8'h00, 32);
      cmd(OP_SUSPEND, 8'h00, 8);
      check("suspended", {7'h0, busy}, 8'h00);
      rdsr(OP_RD2, 8'h04, "paused flag");
      cmd(OP_RESUME, 8'h00, 8);
      rdsr(OP_RD2, 8'h00, "resumed");
      wait_idle();
      cmd(OP_ENTER4, 8'h00, 8);
      check("width4", {7'h0, aw}, 8'h01);
      rdsr(OP_RD3, 8'h01, "sr3 width");
      cmd(OP_EXIT4, 8'h00, 8);
      check("width3", {7'h0, aw}, 8'h00);
      wsr(OP_WR3, 8'h02);
      cmd(OP_RST_ARM, 8'h00, 8);
      cmd(OP_RST_GO, 8'h00, 8);
      check("width boot", {7'h0, aw}, 8'h01);
      cmd(OP_VWREN, 8'h00, 8);
      cmd(OP_WR3, 8'h00, 16);
      wait_idle();
      rdsr(OP_RD3, 8'h03, "width kept");
      $display("test suspend width done");
      cmd(OP_WREN, 8'h00, 8);
      i_host.xfer({OP_RD1, 40'h0}, 16, 10, 1'b0, rd);
      check("paused float", {7'h0, i_host.seen_oe_n}, 8'h01);
      check("resumed read", rd, 8'h02);
      cmd(OP_WRDI, 8'h00, 8);
      i_host.xfer({OP_WREN, 40'h0}, 9, 8, 1'b1, rd);
      rdsr(OP_RD1, 8'h00, "abort");
      $display("test pause done");
      wsr(OP_WR3, 8'h80);
      cmd(OP_WREN, 8'h00, 8);
      i_host.xfer({OP_RD1, 40'h0}, 16, 10, 1'b1, rd);
      rdsr(OP_RD1, 8'h00, "pin reset");
      wsr(OP_WR2, 8'h02);
      cmd(OP_WREN, 8'h00, 8);
      i_host.xfer({OP_RD1, 40'h0}, 16, 10, 1'b1, rd);
      rdsr(OP_RD1, 8'h02, "quad pins");
      wsr(OP_WR2, 8'h00);
      wsr(OP_WR3, 8'h00);
      cmd(OP_DIE_SEL, 8'h01, 16);
      cmd(OP_WREN, 8'h00, 8);
      cmd(OP_DIE_SEL, 8'h00, 16);
      rdsr(OP_RD1, 8'h00, "idle die");
      $display("test pins die done");
      wsr(OP_WR2, 8'h08);
      check("secure", {5'h0, lb}, 8'h01);
      wsr(OP_WR2, 8'h40);
      check("secure kept", {5'h0, lb}, 8'h01);
      wsr(OP_WR1, 8'h1c);
      wsr(OP_WR3, 8'h04);
      check("scheme", {7'h0, scheme}, 8'h01);
      check("guard off", {2'h0, gi, gb}, 8'h00);
      wsr(OP_WR3, 8'h00);
      check("scheme kept", {7'h0, scheme}, 8'h01);
      cmd(OP_RST_ARM, 8'h00, 8);
      cmd(OP_RST_GO, 8'h00, 8);
      check("preset", {7'h0, preset_seen}, 8'h01);
      $display("test otp done");
      give_verdict();
   end
endmodule
`default_nettype wire
